// *** src/dlocf_map.svh ***
`ifndef DLOCF_MAP_SVH
`define DLOCF_MAP_SVH
`define DLOCF_FRAME_BITS 32
`define DLOCF_CMD_HI 27
`define DLOCF_CMD_LO 24
`define DLOCF_CMD_LOAD_OVR 4'h6
`define DLOCF_CMD_CLR_SEL 4'h5
`define DLOCF_CMD_WRITE_UPD 4'h3
`define DLOCF_CLR_CODE_00 16'h0000
`define DLOCF_CLR_CODE_01 16'h8000
`define DLOCF_CLR_CODE_10 16'hffff
`define DLOCF_MASK_RESET 4'h0
`define DLOCF_CLR_RESET 16'h0000
`define DLOCF_SCLK_HALF 4
// controller register byte addresses
`define DLOCF_ADR_FRAME 4'h0
`define DLOCF_ADR_STATUS 4'h4
`endif

// *** src/dlocf_pkg.sv ***
package dlocf_pkg;
  typedef logic [31:0] dlocf_frame_t;
  typedef logic [15:0] dlocf_code_t;
  typedef logic [3:0] dlocf_mask_t;
endpackage

// *** src/dlocf_link_if.sv ***
`timescale 1ns/1ps
interface dlocf_link_if;
  logic sclk;
  logic sdin;
  logic sync_n;
  modport host (output sclk, output sdin, output sync_n);
  modport device (input sclk, input sdin, input sync_n);
endinterface // dlocf_link_if

// *** src/dlocf_skid.sv ***
`timescale 1ns/1ps
module dlocf_skid (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire dlocf_pkg::dlocf_frame_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output dlocf_pkg::dlocf_frame_t out_data_o
);
  import dlocf_pkg::*;
  // ************
  // two-entry buffer
  // ************
  dlocf_frame_t mem_reg [2];
  logic wp_reg, rp_reg;
  logic [1:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = cnt_reg != 2'd2;
  assign out_valid_o = cnt_reg != 2'd0;
  assign out_data_o = mem_reg[rp_reg];
  always_ff @(posedge clk_i) begin
    if (push) mem_reg[wp_reg] <= in_data_i;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // dlocf_skid

// *** src/dlocf_host.sv ***
`timescale 1ns/1ps
`include "dlocf_map.svh"
module dlocf_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  dlocf_link_if.host link
);
  import dlocf_pkg::*;
  // ************
  // wishbone slave
  // ************
  logic ack_reg;
  logic [31:0] rd_reg;
  logic q_valid, q_ready, f_valid, f_ready;
  dlocf_frame_t f_data;
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_frame = req && wb_we_i && wb_adr_i == `DLOCF_ADR_FRAME && (&wb_sel_i);
  // a frame write waits for buffer room, so no full-word write (all four byte selects set) is ever dropped
  wire take = req && !(wr_frame && !q_ready);
  assign q_valid = wr_frame;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  typedef enum {idle, shift, done} dlocf_hst_t;
  dlocf_hst_t st_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= take;
      if (take && !wb_we_i) rd_reg <= (wb_adr_i == `DLOCF_ADR_STATUS) ?
          {30'h0, f_valid, st_reg != idle} : 32'h0;
    end
  end
  dlocf_skid u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(q_valid && take),
    .in_ready_o(q_ready),
    .in_data_i(wb_dat_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  // ************
  // serial master: clock idles low, data changes on rising edge
  // ************
  // the msb is already on the wire when sync falls, so the first rising edge
  // must not shift, and every later bit settles a half period before its fall
  logic [2:0] div_reg;
  logic [5:0] bit_reg;
  dlocf_frame_t sh_reg;
  logic sclk_reg, sync_n_reg;
  assign f_ready = st_reg == idle;
  assign link.sclk = sclk_reg;
  assign link.sdin = sh_reg[31];
  assign link.sync_n = sync_n_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= idle;
      div_reg <= 3'd0;
      bit_reg <= 6'd0;
      sh_reg <= 32'h0;
      sclk_reg <= 1'b0;
      sync_n_reg <= 1'b1;
    end else begin
      unique case (st_reg)
        idle: begin
          sclk_reg <= 1'b0;
          sync_n_reg <= 1'b1;
          if (f_valid) begin
            sh_reg <= f_data;
            sync_n_reg <= 1'b0;
            div_reg <= 3'd0;
            bit_reg <= 6'd0;
            st_reg <= shift;
          end
        end
        shift: begin
          // sync stays low across all four bytes
          if (div_reg == 3'(`DLOCF_SCLK_HALF - 1)) begin
            div_reg <= 3'd0;
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              bit_reg <= bit_reg + 6'd1;
              if (bit_reg == 6'(`DLOCF_FRAME_BITS - 1)) st_reg <= done;
            end else if (bit_reg != 6'd0) begin
              sh_reg <= {sh_reg[30:0], 1'b0};
            end
          end else begin
            div_reg <= div_reg + 3'd1;
          end
        end
        done: begin
          // sync rises a half period after the last fall, then stays high a
          // half period more so the device sees the frame boundary
          if (div_reg == 3'(`DLOCF_SCLK_HALF - 1)) begin
            div_reg <= 3'd0;
            sync_n_reg <= 1'b1;
            if (sync_n_reg) st_reg <= idle;
          end else begin
            div_reg <= div_reg + 3'd1;
          end
        end
      endcase
    end
  end
endmodule // dlocf_host

// *** src/dlocf_device.sv ***
`timescale 1ns/1ps
`include "dlocf_map.svh"
module dlocf_device (
  input wire logic clk_i,
  input wire logic rst_i,
  dlocf_link_if.device link,
  input wire logic load_strobe_n_i,
  input wire logic clear_in_n_i,
  output dlocf_pkg::dlocf_mask_t override_mask_o,
  output dlocf_pkg::dlocf_code_t clear_code_o,
  output dlocf_pkg::dlocf_mask_t dac_update_o,
  output logic clear_pulse_o
);
  import dlocf_pkg::*;
  function automatic dlocf_code_t clr_decode(input logic [1:0] s, input dlocf_code_t old);
    unique case (s)
      2'b00: clr_decode = `DLOCF_CLR_CODE_00;
      2'b01: clr_decode = `DLOCF_CLR_CODE_01;
      2'b10: clr_decode = `DLOCF_CLR_CODE_10;
      2'b11: clr_decode = old;
    endcase
  endfunction
  // ************
  // pin synchronisers
  // ************
  logic [1:0] s1_reg, s2_reg, s3_reg, s4_reg, s5_reg;
  logic sclk_d_reg, clr_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // reset at the idle level of each pin, so no false edge follows reset
      s1_reg <= 2'b00;
      s2_reg <= 2'b11;
      s3_reg <= 2'b00;
      s4_reg <= 2'b11;
      s5_reg <= 2'b11;
      sclk_d_reg <= 1'b0;
      clr_d_reg <= 1'b1;
    end else begin
      s1_reg <= {s1_reg[0], link.sclk};
      s2_reg <= {s2_reg[0], link.sync_n};
      s3_reg <= {s3_reg[0], link.sdin};
      s4_reg <= {s4_reg[0], clear_in_n_i};
      s5_reg <= {s5_reg[0], load_strobe_n_i};
      sclk_d_reg <= s1_reg[1];
      clr_d_reg <= s4_reg[1];
    end
  end
  wire sclk_fall = sclk_d_reg && !s1_reg[1];
  wire clr_fall = clr_d_reg && !s4_reg[1];
  // ************
  // frame shifter: sample on falling clock, msb first
  // ************
  dlocf_frame_t sh_reg;
  logic [5:0] cnt_reg;
  dlocf_mask_t ovr_reg, upd_reg;
  dlocf_code_t clr_reg;
  logic clrp_reg;
  wire dlocf_frame_t word = {sh_reg[30:0], s3_reg[1]};
  wire last = sclk_fall && !s2_reg[1] && cnt_reg == 6'(`DLOCF_FRAME_BITS - 1);
  wire [3:0] cmd = word[`DLOCF_CMD_HI:`DLOCF_CMD_LO];
  // effective strobe per channel: override forces it low
  wire dlocf_mask_t eff_low = ovr_reg | {4{~s5_reg[1]}};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 32'h0;
      cnt_reg <= 6'd0;
    end else if (s2_reg[1] || clr_fall) begin
      // sync high or a clear aborts any partial frame
      cnt_reg <= 6'd0;
    end else if (sclk_fall) begin
      sh_reg <= word;
      cnt_reg <= last ? 6'd0 : cnt_reg + 6'd1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_reg <= `DLOCF_MASK_RESET;
      clr_reg <= `DLOCF_CLR_RESET;
    end else if (last && !clr_fall) begin
      if (cmd == `DLOCF_CMD_LOAD_OVR) ovr_reg <= word[3:0];
      if (cmd == `DLOCF_CMD_CLR_SEL) clr_reg <= clr_decode(word[1:0], clr_reg);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_reg <= 4'h0;
      clrp_reg <= 1'b0;
    end else begin
      clrp_reg <= clr_fall;
      // data frames update channels whose strobe is effectively low at frame end
      upd_reg <= (last && !clr_fall && cmd == `DLOCF_CMD_WRITE_UPD) ? eff_low : 4'h0;
    end
  end
  assign override_mask_o = ovr_reg;
  assign clear_code_o = clr_reg;
  assign dac_update_o = upd_reg;
  assign clear_pulse_o = clrp_reg;
endmodule // dlocf_device

// *** testbench/dlocf_link_props.sv ***
`timescale 1ns/1ps
module dlocf_link_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sync_n
);
  // ****
  // link wire checks
  // ****
  logic sclk_reg;
  logic [5:0] falls_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // falls are counted per frame, so a short or long frame shows at sync release
  always_ff @(posedge clk_i) begin
    sclk_reg <= sclk;
    if (rst_i || sync_n) falls_reg <= 6'h00;
    else if (sclk_reg && !sclk) falls_reg <= falls_reg + 6'h01;
  end
  property p_idle; sync_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock moved outside frame");
  property p_half; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("clock high phase wrong");
  property p_low; $fell(sclk) |-> !sclk[*4]; endproperty
  a_low: assert property (p_low) else $error("clock low phase short");
  property p_data; $fell(sclk) |-> $stable(sdin); endproperty
  a_data: assert property (p_data) else $error("data moved at falling clock");
  property p_first; $fell(sync_n) |-> !sclk; endproperty
  a_first: assert property (p_first) else $error("clock high as sync fell");
  property p_count; $rose(sync_n) |-> falls_reg == 6'h20; endproperty
  a_count: assert property (p_count) else $error("frame not 32 falls");
  property p_keep; sclk |-> !sync_n; endproperty
  a_keep: assert property (p_keep) else $error("sync high in clock pulse");
  property p_gap; $rose(sync_n) |-> sync_n[*4]; endproperty
  a_gap: assert property (p_gap) else $error("sync gap short");
endmodule // dlocf_link_props

// *** testbench/test_dac_load_override_clear_frame.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_dac_load_override_clear_frame;
  import dlocf_pkg::*;
  // ****
  // harness
  // ****
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic clr_n = 1'b1;
  logic ld_n = 1'b1;
  dlocf_mask_t upd;
  dlocf_mask_t upd_cap = 4'h0;
  int n_upd = 0;
  logic [31:0] rdat;
  logic ack;
  dlocf_mask_t mask;
  dlocf_code_t code;
  logic clr_p;
  logic sclk_q;
  dlocf_frame_t cap;
  int n_mismatch = 0;
  int checked = 0;
  dlocf_link_if link ();
  always #20 clk_i = ~clk_i;
  dlocf_host dlocf_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .link(link.host));
  dlocf_device dlocf_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link.device),
    .load_strobe_n_i(ld_n), .clear_in_n_i(clr_n), .override_mask_o(mask),
    .clear_code_o(code), .dac_update_o(upd), .clear_pulse_o(clr_p));
  dlocf_link_props dlocf_link_props_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk),
    .sdin(link.sdin), .sync_n(link.sync_n));
  // the bench shifts the wire itself, so bit order is judged apart from the device
  always @(posedge clk_i) begin
    sclk_q <= link.sclk;
    if (!link.sync_n && sclk_q && !link.sclk) cap <= {cap[30:0], link.sdin};
  end
  // update pulses last one cycle, so the last one and a running count are kept
  always @(posedge clk_i) begin
    if (|upd) begin
      upd_cap <= upd;
      n_upd <= n_upd + 1;
    end
  end
  task automatic test_done();
    $display("counts checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    // a full buffer stalls ack for a whole frame
    for (k = 0; k < 600 && ack !== 1'b1; k++) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 600) begin n_mismatch++; test_done(); end
    @(posedge clk_i);
  endtask
  task automatic wsync(input logic v);
    int k;
    for (k = 0; k < 400 && link.sync_n !== v; k++) @(posedge clk_i);
    if (k == 400) begin n_mismatch++; test_done(); end
  endtask
  task automatic frame(input dlocf_frame_t w);
    logic [31:0] q;
    wb(4'h0, 1'b1, w, q);
    wsync(1'b0);
    wsync(1'b1);
    repeat (6) @(posedge clk_i);
    `CHK(cap, w)
  endtask
  task automatic t_mask();
    frame(32'hf6f0_fff5);
    `CHK(mask, 4'h5)
    frame(32'h06ff_fffa);
    `CHK(mask, 4'ha)
    $display("test mask done");
  endtask
  task automatic t_clear_sel();
    logic [1:0] sel [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    dlocf_code_t exp [4] = '{16'hffff, 16'hffff, 16'h8000, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      frame({30'h3d7f_ffff, sel[i]});
      `CHK(code, exp[i])
      `CHK(mask, 4'ha)
    end
    $display("test clear select done");
  endtask
  task automatic t_clear_pin();
    logic [31:0] q;
    int k;
    wb(4'h0, 1'b1, 32'h0600_0003, q);
    wsync(1'b0);
    repeat (100) @(posedge clk_i);
    clr_n <= 1'b0;
    for (k = 0; k < 10 && clr_p !== 1'b1; k++) @(posedge clk_i);
    `CHK(clr_p, 1'b1)
    @(posedge clk_i);
    `CHK(clr_p, 1'b0)
    clr_n <= 1'b1;
    wsync(1'b1);
    repeat (6) @(posedge clk_i);
    `CHK(mask, 4'ha)
    $display("test clear pin done");
  endtask
  task automatic t_buf();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) wb(4'h0, 1'b1, 32'h0600_0000 | (32'h1 << i), q);
    // shifter busy and two frames waiting in the buffer
    wb(4'h4, 1'b0, 32'h0, q);
    `CHK(q, 32'h3)
    // the fourth write stalls until the second frame starts, so three remain
    for (int i = 0; i < 3; i++) begin
      wsync(1'b0);
      wsync(1'b1);
    end
    repeat (6) @(posedge clk_i);
    `CHK(mask, 4'h8)
    `CHK(cap, 32'h0600_0008)
    wb(4'h4, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    wb(4'h8, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    $display("test buffer done");
  endtask
  task automatic t_update();
    int n0;
    ld_n <= 1'b1;
    n0 = n_upd;
    frame(32'h0300_1234);
    `CHK(upd_cap, 4'h8)
    `CHK(n_upd, n0 + 1)
    ld_n <= 1'b0;
    frame(32'h0300_abcd);
    `CHK(upd_cap, 4'hf)
    frame(32'h0600_0000);
    `CHK(mask, 4'h0)
    ld_n <= 1'b1;
    n0 = n_upd;
    frame(32'h0300_5555);
    `CHK(n_upd, n0)
    $display("test update done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(mask, 4'h0)
    `CHK(code, 16'h0000)
    `CHK(link.sclk, 1'b0)
    $display("test reset done");
    t_mask();
    t_clear_sel();
    t_clear_pin();
    t_buf();
    t_update();
    test_done();
  end
endmodule // test_dac_load_override_clear_frame
